//--- udar_map.svh
// Constants for the undefined decode, abort restore block
`ifndef UDAR_MAP_SVH
`define UDAR_MAP_SVH
`define UDAR_UNDEF_OP_VAL 3'h3
`define UDAR_PC_STORE_OFS 32'h0000000C
`define UDAR_SYSCP_NUM 4'hF
`define UDAR_NARROW_INS_BYTES 32'h00000002
`define UDAR_WIDE_INS_BYTES 32'h00000004
`define UDAR_NREGS 16
`endif

//--- udar_pkg.sv
// Types for the undefined decode, abort restore block
package udar_pkg;
  typedef enum logic [1:0] {
    UDAR_ST_FETCH = 2'b00,
    UDAR_ST_EXEC = 2'b01,
    UDAR_ST_MEM = 2'b10,
    UDAR_ST_WB = 2'b11
  } udar_stage_e;
  typedef struct packed {
    logic valid;
    logic undef;
    logic store_pc;
    logic wb_base;
    logic [3:0] base_reg;
    logic [31:0] addr;
  } udar_dec_s;
  typedef struct packed {
    logic valid;
    logic [3:0] reg_idx;
    logic [31:0] value;
  } udar_save_s;
endpackage

//--- udar_base_mem.sv
// Snapshot memory holding base register values per register index
module udar_base_mem #(
  parameter int NREGS = 16
) (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] rd_idx,
  output logic [31:0] rd_data
);
  logic [31:0] mem_q [NREGS];
  logic [31:0] rd_q;
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem_q[wr_idx] <= wr_data;
    end
    rd_q <= mem_q[rd_idx];
  end
  assign rd_data = rd_q;
endmodule

//--- udar_decode.sv
// Decode stage: undefined detection, abort base restore, stored pc value
`include "udar_map.svh"
// Summary of operation
// - Bits 27:25 011 with bit4 undefined
// - Unassigned extension space encodings are undefined
// - Data abort restores base register old value
// - Stored pc equals instruction address plus 12
// - Five stages: fetch decode execute memory writeback
// - Decode 32 or 16 bit per state
// - System coprocessor misuse raises undefined trap
module udar_decode (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_instr,
  input wire logic [31:0] fetch_addr,
  input wire logic narrow_state,
  input wire logic priv_mode,
  input wire logic [31:0] base_value,
  input wire logic data_abort,
  input wire logic flush,
  output logic undef_exc,
  output logic [31:0] store_pc_value,
  output logic store_pc_valid,
  output logic restore_valid,
  output logic [3:0] restore_reg,
  output logic [31:0] restore_value,
  output logic wb_base_en
);
  ////////////////////////////////////////////////////////////////////////
  function automatic logic wide_undef(input logic [31:0] ins, input logic priv);
    logic u;
    u = 1'b0;
    if (ins[27:25] == `UDAR_UNDEF_OP_VAL && ins[4]) begin
      u = 1'b1;
    end
    // Arithmetic extension: only multiplies and long multiplies assigned
    if (ins[27:24] == 4'h0 && ins[7:4] == 4'h9 && ins[23:22] != 2'b00 && ins[23] == 1'b0) begin
      u = 1'b1;
    end
    // Control extension: misc ops with bits 7:4 not 0 or 9, except bits 22:21 01 with bits 7:4 1
    if (ins[27:23] == 5'b00010 && ins[20] == 1'b0 && ins[7:4] != 4'h0 && ins[7:4] != 4'h9
        && !(ins[22:21] == 2'b01 && ins[7:4] == 4'h1)) begin
      u = 1'b1;
    end
    // Load/store extension: store forms (bit20 clear) with bit6 of the halfword bits set
    if (ins[27:25] == 3'h0 && ins[7] && ins[4] && ins[6:5] != 2'b00 && !ins[20] && ins[6]) begin
      u = 1'b1;
    end
    // Coprocessor extension: double-register space
    if (ins[27:23] == 5'b11000 && ins[21] == 1'b0) begin
      u = 1'b1;
    end
    if (ins[11:8] == `UDAR_SYSCP_NUM && ins[27:26] == 2'b11) begin
      if (ins[25:24] != 2'b10 || !ins[4] || !priv) begin
        u = 1'b1;
      end
    end
    return u;
  endfunction
  function automatic logic narrow_undef(input logic [15:0] ins);
    return ins[15:12] == 4'hD && ins[11:8] == 4'hE;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  udar_pkg::udar_dec_s dec_q, dec_d, ex_q, ex_d, mem_q, mem_d;
  logic undef_q, undef_d, spv_q, spv_d, rv_q, rv_d, wb_q, wb_d, rd_pend_q, rd_pend_d;
  logic [31:0] spval_q, spval_d;
  logic [3:0] rreg_q, rreg_d;
  logic [31:0] snap_rd;
  logic is_store_pc, is_wb;
  logic [3:0] breg;
  logic [31:0] rval_q, rval_d;
  always_comb begin
    is_store_pc = 1'b0;
    is_wb = 1'b0;
    breg = fetch_instr[19:16];
    if (!narrow_state) begin
      if (fetch_instr[27:26] == 2'b01 && !fetch_instr[20] && fetch_instr[15:12] == 4'hF) begin
        is_store_pc = 1'b1;
      end
      if (fetch_instr[27:25] == 3'h4 && !fetch_instr[20] && fetch_instr[15]) begin
        is_store_pc = 1'b1;
      end
      is_wb = fetch_instr[27:26] == 2'b01 ? (fetch_instr[21] || !fetch_instr[24])
            : (fetch_instr[27:25] == 3'h4 && fetch_instr[21]);
    end else begin
      breg = {1'b0, fetch_instr[10:8]};
      is_wb = fetch_instr[15:12] == 4'hC;
    end
  end
  // Pipeline advance, one stage per cycle
  always_comb begin
    dec_d = '0;
    dec_d.valid = fetch_valid && !flush;
    dec_d.undef = narrow_state ? narrow_undef(fetch_instr[15:0])
                               : wide_undef(fetch_instr, priv_mode);
    dec_d.store_pc = is_store_pc;
    dec_d.wb_base = is_wb;
    dec_d.base_reg = breg;
    dec_d.addr = fetch_addr;
    ex_d = flush ? '0 : dec_q;
    mem_d = flush ? '0 : ex_q;
    // Exception only when instruction reaches execute, so speculative fetch is harmless
    undef_d = ex_d.valid && ex_d.undef;
    spv_d = ex_d.valid && ex_d.store_pc && !ex_d.undef;
    spval_d = ex_d.addr + `UDAR_PC_STORE_OFS;
    rd_pend_d = data_abort && mem_q.valid && mem_q.wb_base;
    rv_d = rd_pend_q;
    rreg_d = rd_pend_q ? rreg_q : mem_q.base_reg;
    // Writeback suppressed when the memory stage aborts
    wb_d = mem_q.valid && mem_q.wb_base && !data_abort;
    rval_d = rd_pend_q ? snap_rd : rval_q;
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dec_q <= '0;
      ex_q <= '0;
      mem_q <= '0;
      undef_q <= 1'b0;
      spv_q <= 1'b0;
      spval_q <= '0;
      rd_pend_q <= 1'b0;
      rv_q <= 1'b0;
      rreg_q <= '0;
      wb_q <= 1'b0;
    end else begin
      dec_q <= dec_d;
      ex_q <= ex_d;
      mem_q <= mem_d;
      undef_q <= undef_d;
      spv_q <= spv_d;
      spval_q <= spval_d;
      rd_pend_q <= rd_pend_d;
      rv_q <= rv_d;
      rreg_q <= rreg_d;
      wb_q <= wb_d;
    end
  end
  // Snapshot of base taken at decode, read back one cycle after abort
  udar_base_mem #(.NREGS(`UDAR_NREGS)) u_mem (
    .ref_clk(ref_clk),
    .wr_en(dec_d.valid && is_wb),
    .wr_idx(breg),
    .wr_data(base_value),
    .rd_idx(mem_q.base_reg),
    .rd_data(snap_rd)
  );
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rval_q <= '0;
    end else begin
      rval_q <= rval_d;
    end
  end
  assign undef_exc = undef_q;
  assign store_pc_valid = spv_q;
  assign store_pc_value = spval_q;
  assign restore_valid = rv_q;
  assign restore_reg = rreg_q;
  assign restore_value = rval_q;
  assign wb_base_en = wb_q;
  ////////////////////////////////////////////////////////////////////////
  // Fetch sampled, one clean cycle in decode, exception flagged the cycle after
  property p_r1;
    @(posedge ref_clk) disable iff (srst)
      (fetch_valid && !flush && !narrow_state && fetch_instr[27:25] == 3'h3
       && fetch_instr[4]) ##1 !flush |=> undef_exc;
  endproperty
  a_r1: assert property (p_r1) else $error("undefined space not trapped");
  property p_r2;
    @(posedge ref_clk) disable iff (srst)
      (fetch_valid && !flush && !narrow_state && fetch_instr[27:23] == 5'h18
       && !fetch_instr[21]) ##1 !flush |=> undef_exc;
  endproperty
  a_r2: assert property (p_r2) else $error("coprocessor extension space not trapped");
  property p_r6;
    @(posedge ref_clk) disable iff (srst)
      (fetch_valid && !flush && narrow_state && fetch_instr[15:8] == 8'hDE)
      ##1 !flush |=> undef_exc;
  endproperty
  a_r6: assert property (p_r6) else $error("short undefined form not trapped");
  // Value registers alongside execute, so the decode address one edge back is the source
  property p_r4;
    @(posedge ref_clk) disable iff (srst)
      store_pc_valid |-> store_pc_value == $past(dec_q.addr) + `UDAR_PC_STORE_OFS;
  endproperty
  a_r4: assert property (p_r4) else $error("stored pc value wrong");
  sequence s_restore_steps;
    !wb_base_en ##1 restore_valid;
  endsequence
  property p_r3;
    @(posedge ref_clk) disable iff (srst)
      (data_abort && mem_q.valid && mem_q.wb_base) |=> s_restore_steps;
  endproperty
  a_r3: assert property (p_r3) else $error("aborted base not restored");
  property p_r8;
    @(posedge ref_clk) disable iff (srst)
      undef_exc |-> ex_q.valid && ex_q.undef && !$past(flush);
  endproperty
  a_r8: assert property (p_r8) else $error("undef raised without instruction");
  property p_r7;
    @(posedge ref_clk) disable iff (srst)
      (fetch_valid && !flush && !narrow_state && !priv_mode && fetch_instr[27:24] == 4'hE
       && fetch_instr[4] && fetch_instr[11:8] == 4'hF) ##1 !flush |=> undef_exc;
  endproperty
  a_r7: assert property (p_r7) else $error("system coprocessor misuse missed");
endmodule

//--- udar_core_model.sv
// Core pipeline stand-in that feeds the decode stage
module udar_core_model (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic req,
  input wire logic [31:0] req_instr,
  input wire logic [31:0] req_addr,
  input wire logic abort_req,
  input wire logic flush_req,
  output logic fetch_valid,
  output logic [31:0] fetch_instr,
  output logic [31:0] fetch_addr,
  output logic data_abort,
  output logic flush
);
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fetch_valid <= 1'b0;
      fetch_instr <= 32'h00000000;
      fetch_addr <= 32'h00000000;
      data_abort <= 1'b0;
      flush <= 1'b0;
    end else begin
      fetch_valid <= req;
      // Idle bus flips so a stale word is never mistaken for a fetch
      fetch_instr <= req ? req_instr : ~fetch_instr;
      fetch_addr <= req ? req_addr : ~fetch_addr;
      data_abort <= abort_req;
      flush <= flush_req;
    end
  end
endmodule

//--- tb_top.sv
// Self-checking bench for the decode stage
`include "udar_map.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, srst = 1'b1, req = 1'b0, abort_req = 1'b0, flush_req = 1'b0;
  logic narrow_state = 1'b0, priv_mode = 1'b0;
  logic [31:0] req_instr = 32'h0, req_addr = 32'h0, base_value = 32'h0;
  logic fetch_valid, data_abort, flush, undef_exc, store_pc_valid, restore_valid, wb_base_en;
  logic [31:0] fetch_instr, fetch_addr, store_pc_value, restore_value;
  logic [3:0] restore_reg;
  int mismatches = 0;
  int tests_run = 0;
  initial forever #25 ref_clk = ~ref_clk;
  udar_core_model u_udar_core_model (.ref_clk(ref_clk), .srst(srst), .req(req),
    .req_instr(req_instr), .req_addr(req_addr), .abort_req(abort_req), .flush_req(flush_req),
    .fetch_valid(fetch_valid), .fetch_instr(fetch_instr), .fetch_addr(fetch_addr),
    .data_abort(data_abort), .flush(flush));
  udar_decode u_udar_decode (.ref_clk(ref_clk), .srst(srst), .fetch_valid(fetch_valid),
    .fetch_instr(fetch_instr), .fetch_addr(fetch_addr), .narrow_state(narrow_state),
    .priv_mode(priv_mode), .base_value(base_value), .data_abort(data_abort), .flush(flush),
    .undef_exc(undef_exc), .store_pc_value(store_pc_value), .store_pc_valid(store_pc_valid),
    .restore_valid(restore_valid), .restore_reg(restore_reg), .restore_value(restore_value),
    .wb_base_en(wb_base_en));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Fetch one word, optional kill a cycle later, return when the execute result shows
  task automatic send(input logic [31:0] ins, input logic kill);
    @(posedge ref_clk);
    req <= 1'b1;
    req_instr <= ins;
    req_addr <= 32'h00001000;
    @(posedge ref_clk);
    req <= 1'b0;
    flush_req <= kill;
    @(posedge ref_clk);
    flush_req <= 1'b0;
    // Result registers alongside execute, one edge after decode capture
    @(posedge ref_clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_undef();
    send(32'hE6000010, 1'b0);
    check(undef_exc, 1'b1, "undef missed");
    check(store_pc_valid, 1'b0, "undef stored");
    @(posedge ref_clk);
    #1;
    check(undef_exc, 1'b0, "undef not a pulse");
    send(32'hE6000000, 1'b0);
    check(undef_exc, 1'b0, "bit4 clear flagged");
    send(32'hE6000010, 1'b1);
    check(undef_exc, 1'b0, "flushed undef taken");
    send(32'hE0400090, 1'b0);
    check(undef_exc, 1'b1, "arith extension missed");
    send(32'hEC400000, 1'b0);
    check(undef_exc, 1'b1, "coproc extension missed");
    $display("done undef");
  endtask
  task automatic t_store();
    logic [31:0] ops [3] = '{32'hE580F000, 32'hE4A0F000, 32'hE8808000};
    foreach (ops[i]) begin
      send(ops[i], 1'b0);
      check(store_pc_valid, 1'b1, "pc store missed");
      check(store_pc_value, 32'h00001000 + `UDAR_PC_STORE_OFS, "pc value");
      repeat (2) @(posedge ref_clk);
      #1;
      check(wb_base_en, (i == 1), "writeback enable");
    end
    $display("done store");
  endtask
  task automatic t_sysc();
    logic [31:0] ops [4] = '{32'hEE000F00, 32'hED900F00, 32'hEE100F10, 32'hEE100F10};
    foreach (ops[i]) begin
      @(posedge ref_clk);
      priv_mode <= (i == 3);
      send(ops[i], 1'b0);
      check(undef_exc, (i != 3), "sys coproc trap");
    end
    $display("done sysc");
  endtask
  task automatic t_narrow();
    @(posedge ref_clk);
    narrow_state <= 1'b1;
    send(32'h0000DE00, 1'b0);
    check(undef_exc, 1'b1, "short undef missed");
    send(32'hE6000010, 1'b0);
    check(undef_exc, 1'b0, "short form misread");
    @(posedge ref_clk);
    narrow_state <= 1'b0;
    $display("done narrow");
  endtask
  // Abort lands while the load with writeback sits in the memory stage
  task automatic t_abort();
    @(posedge ref_clk);
    base_value <= 32'h00A55A00;
    req <= 1'b1;
    req_instr <= 32'hE4921004;
    req_addr <= 32'h00002000;
    @(posedge ref_clk);
    req <= 1'b0;
    @(posedge ref_clk);
    base_value <= 32'hFFFF0000;
    @(posedge ref_clk);
    abort_req <= 1'b1;
    @(posedge ref_clk);
    abort_req <= 1'b0;
    @(posedge ref_clk);
    #1;
    check(wb_base_en, 1'b0, "aborted writeback kept");
    @(posedge ref_clk);
    #1;
    check(restore_valid, 1'b1, "no restore");
    check(restore_reg, 4'h2, "restore reg");
    check(restore_value, 32'h00A55A00, "restore value");
    $display("done abort");
  endtask
  initial begin
    #100000;
    mismatches++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    t_undef();
    t_store();
    t_sysc();
    t_narrow();
    t_abort();
    close_out();
  end
endmodule
